/* rtl/dcf_pkg.sv */
package dcf_pkg;

    // ------------------------------------------------------------------
    // Data path and depth
    // ------------------------------------------------------------------
    localparam int DATA_W    = 18;
    localparam int DEPTH_DEF = 8192;
    localparam int OFF_W     = 17;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] AE_OFS     = 8'h04;
    localparam logic [7:0] AF_OFS     = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // Field positions
    localparam int CTRL_RETX_BIT  = 0;
    localparam int STAT_FULL_BIT  = 31;
    localparam int STAT_EMPTY_BIT = 30;
    localparam int STAT_AE_BIT    = 29;
    localparam int STAT_AF_BIT    = 28;
    localparam int STAT_MODE_BIT  = 27;

    // Reset values
    localparam logic [OFF_W-1:0] AE_OFF_RST = 17'h00007;
    localparam logic [OFF_W-1:0] AF_OFF_RST = 17'h00007;
    localparam logic             MODE_RST   = 1'b1;
    localparam logic             OE_N_RST   = 1'b1;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         CLK_NS  = 40;
    localparam int         RTR_NS  = 90;
    localparam logic [3:0] RTR_CYC = 4'((RTR_NS + CLK_NS - 1) / CLK_NS);

    // Retransmit sequencer
    typedef enum logic [1:0] {
        DCF_RUN   = 2'b00,
        DCF_RECOV = 2'b01
    } dcf_rtr_state_t;

endpackage

/* rtl/dcf_store.sv */
`timescale 1ns/10ps
module dcf_store #(
    parameter int W     = 18,
    parameter int DEPTH = 8192,
    parameter int AW    = 13
) (
    input  wire logic          clk_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [W-1:0]  wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [W-1:0]  rd_data_o
);

    // ------------------------------------------------------------------
    // Flip-flop array, no reset: contents are undefined until written
    // ------------------------------------------------------------------
    logic [W-1:0] mem_q [DEPTH];

    // Single write port
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Read is combinational; the top registers it
    assign rd_data_o = mem_q[rd_addr_i];

endmodule // dcf_store

/* rtl/dcf_fifo.sv */
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
// Functional notes
// - Full flag clears on the same edge
// - Empty flag clears on the same edge
// - Reset holds whatever the clock does
// - After reset, output low or released per enable
// - First word readable cycle after empty clears
// - First-read latency applies only from empty
// - Sync mode: almost-empty registered one edge later
// - Sync mode: almost-full registered one edge later
// - Almost-empty low at n minus one words
// - Almost-full low at depth minus m words
// - Flags valid after retransmit recovery time
// - Mode select low registers almost flags
module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]                 s_axi_awaddr_i,
    input  wire logic                       s_axi_awvalid_i,
    output logic                            s_axi_awready_o,
    input  wire logic [31:0]                s_axi_wdata_i,
    input  wire logic [3:0]                 s_axi_wstrb_i,
    input  wire logic                       s_axi_wvalid_i,
    output logic                            s_axi_wready_o,
    output logic [1:0]                      s_axi_bresp_o,
    output logic                            s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic [7:0]                 s_axi_araddr_i,
    input  wire logic                       s_axi_arvalid_i,
    output logic                            s_axi_arready_o,
    output logic [31:0]                     s_axi_rdata_o,
    output logic [1:0]                      s_axi_rresp_o,
    output logic                            s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    // Writer and reader
    input  wire logic                       wr_en_i,
    input  wire logic [dcf_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                       rd_en_i,
    output logic      [dcf_pkg::DATA_W-1:0] rd_data_o,
    output logic                            rd_data_oe_o,
    input  wire logic                       out_en_n_i,
    input  wire logic                       flag_sync_mode_sel_i,
    output logic                            full_flag_n_o,
    output logic                            empty_flag_n_o,
    output logic                            almost_empty_flag_n_o,
    output logic                            almost_full_flag_n_o
);
    import dcf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // Clocks may run freely during reset; release is synchronous
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Pin inputs: three stages, change taken when stages two and three agree
    // ------------------------------------------------------------------
    logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic       mode_async, oe_n;

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= {MODE_RST, OE_N_RST};
            pin_s2_q <= {MODE_RST, OE_N_RST};
            pin_s3_q <= {MODE_RST, OE_N_RST};
            pin_q    <= {MODE_RST, OE_N_RST};
        end
        else
        begin
            pin_s1_q <= {flag_sync_mode_sel_i, out_en_n_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < 2; i++)
            begin
                if (pin_s2_q[i] == pin_s3_q[i])
                    pin_q[i] <= pin_s3_q[i];
            end
        end
    end
    assign mode_async = pin_q[1];
    assign oe_n       = pin_q[0];

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [7:0]       aw_addr_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;
    logic             aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
    logic [1:0]       bresp_q, rresp_q;
    logic             arready_q, rvalid_q;
    logic [31:0]      rdata_q;
    logic [OFF_W-1:0] ae_off_q, af_off_q;
    logic             wr_exec, retx_go, wr_mapped;
    logic [CW-1:0]    count_q;

    assign wr_exec   = aw_have_q && w_have_q && !bvalid_q;
    assign wr_mapped = (aw_addr_q == CTRL_OFS) || (aw_addr_q == AE_OFS)
                    || (aw_addr_q == AF_OFS) || (aw_addr_q == STATUS_OFS);
    assign retx_go   = wr_exec && (aw_addr_q == CTRL_OFS) && w_strb_q[0]
                    && w_data_q[CTRL_RETX_BIT];

    // Write channels: address and data taken in either order, one at a time
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && awready_q)
            begin
                aw_addr_q <= s_axi_awaddr_i;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_q)
            begin
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_exec)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready_i)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Offset registers; byte lanes above bit 16 are ignored
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ae_off_q <= AE_OFF_RST;
            af_off_q <= AF_OFF_RST;
        end
        else if (wr_exec)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (w_strb_q[b] && aw_addr_q == AE_OFS)
                    for (int k = 8*b; k < 8*b+8 && k < OFF_W; k++)
                        ae_off_q[k] <= w_data_q[k];
                if (w_strb_q[b] && aw_addr_q == AF_OFS)
                    for (int k = 8*b; k < 8*b+8 && k < OFF_W; k++)
                        af_off_q[k] <= w_data_q[k];
            end
        end
    end

    // Read channel: data registered on the same edge that takes the address
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end
        else if (s_axi_arvalid_i && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            if (s_axi_araddr_i == CTRL_OFS)
                rdata_q <= 32'h0000_0000;
            else if (s_axi_araddr_i == AE_OFS)
                rdata_q <= 32'(ae_off_q);
            else if (s_axi_araddr_i == AF_OFS)
                rdata_q <= 32'(af_off_q);
            else if (s_axi_araddr_i == STATUS_OFS)
            begin
                rdata_q                 <= 32'(count_q);
                rdata_q[STAT_FULL_BIT]  <= !full_flag_n_o;
                rdata_q[STAT_EMPTY_BIT] <= !empty_flag_n_o;
                rdata_q[STAT_AE_BIT]    <= !almost_empty_flag_n_o;
                rdata_q[STAT_AF_BIT]    <= !almost_full_flag_n_o;
                rdata_q[STAT_MODE_BIT]  <= mode_async;
            end
            else
            begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= RESP_SLVERR;
            end
        end
        else if (rvalid_q && s_axi_rready_i)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    // ------------------------------------------------------------------
    // Retransmit sequencer
    // ------------------------------------------------------------------
    dcf_rtr_state_t state_q;
    logic [3:0]     rtr_cnt_q;

    // Reader and writer are held off until the flags have settled
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q   <= DCF_RUN;
            rtr_cnt_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                DCF_RUN:
                begin
                    if (retx_go)
                    begin
                        state_q   <= DCF_RECOV;
                        rtr_cnt_q <= RTR_CYC;
                    end
                end
                DCF_RECOV:
                begin
                    rtr_cnt_q <= rtr_cnt_q - 4'h1;
                    if (rtr_cnt_q == 4'h1)
                        state_q <= DCF_RUN;
                end
                default:
                    state_q <= DCF_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pointers, count and flags
    // ------------------------------------------------------------------
    logic [AW-1:0]         wr_ptr_q, rd_ptr_q;
    logic [CW-1:0]         count_d;
    logic                  wr_ok, rd_ok;
    logic [DATA_W-1:0]     mem_rd;
    logic [DATA_W-1:0]     rd_data_q;
    logic                  oe_q, full_n_q, empty_n_q, ae_n_q, af_n_q;

    // One clock serves both sides, so the skew window is always met
    assign wr_ok = wr_en_i && (count_q != DEPTH_C) && (state_q == DCF_RUN);
    assign rd_ok = rd_en_i && (count_q != '0) && (state_q == DCF_RUN);

    // Retransmit replays from the first location; count is what was written,
    // including a write taken on the same edge so that word is not lost
    always_comb
    begin
        if (retx_go)
            count_d = CW'(wr_ptr_q) + CW'(wr_ok);
        else
            count_d = count_q + CW'(wr_ok) - CW'(rd_ok);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            count_q <= count_d;
            if (wr_ok)
                wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + AW'(1);
            if (retx_go)
                rd_ptr_q <= '0;
            else if (rd_ok)
                rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + AW'(1);
        end
    end

    // Full and empty follow the next count on the same edge
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            full_n_q  <= 1'b1;
            empty_n_q <= 1'b0;
        end
        else
        begin
            full_n_q  <= (count_d != DEPTH_C);
            empty_n_q <= (count_d != '0);
        end
    end

    // Almost flags: next count when asynchronous, present count when synchronous
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ae_n_q <= 1'b0;
            af_n_q <= 1'b1;
        end
        else if (mode_async)
        begin
            ae_n_q <= !(32'(count_d) < 32'(ae_off_q));
            af_n_q <= !(32'(count_d) + 32'(af_off_q) >= 32'(DEPTH_C));
        end
        else
        begin
            ae_n_q <= !(32'(count_q) < 32'(ae_off_q));
            af_n_q <= !(32'(count_q) + 32'(af_off_q) >= 32'(DEPTH_C));
        end
    end

    dcf_store #(
        .W     (DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_store (
        .clk_i     (ref_clk_i),
        .wr_en_i   (wr_ok),
        .wr_addr_i (wr_ptr_q),
        .wr_data_i (wr_data_i),
        .rd_addr_i (rd_ptr_q),
        .rd_data_o (mem_rd)
    );

    // Output word; stays low from reset until the first accepted read
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= '0;
            oe_q      <= 1'b0;
        end
        else
        begin
            oe_q <= !oe_n;
            if (rd_ok)
                rd_data_q <= mem_rd;
        end
    end

    assign rd_data_o             = rd_data_q;
    assign rd_data_oe_o          = oe_q;
    assign full_flag_n_o         = full_n_q;
    assign empty_flag_n_o        = empty_n_q;
    assign almost_empty_flag_n_o = ae_n_q;
    assign almost_full_flag_n_o  = af_n_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    logic rd_seen_q;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rd_seen_q <= 1'b0;
        else if (rd_ok)
            rd_seen_q <= 1'b1;
    end

    full_flag_a: assert property (full_flag_n_o == (count_q != DEPTH_C))
        else $error("full flag disagrees with count");
    empty_flag_a: assert property (empty_flag_n_o == (count_q != '0))
        else $error("empty flag disagrees with count");
    write_full_a: assert property (!full_flag_n_o && wr_en_i |=> $stable(wr_ptr_q))
        else $error("write taken while full");
    read_empty_a: assert property (!empty_flag_n_o && rd_en_i && !retx_go
        |=> $stable(rd_ptr_q))
        else $error("read taken while empty");
    data_low_a: assert property (!rd_seen_q |-> rd_data_o == '0)
        else $error("output not low before first read");
    oe_follow_a: assert property (##1 rd_data_oe_o == !$past(oe_n))
        else $error("output enable not following pin");
    first_word_a: assert property (!empty_flag_n_o && wr_ok |=> empty_flag_n_o)
        else $error("write into empty did not clear empty flag");
    sync_ae_a: assert property (!mode_async && $past(!mode_async) && $stable(ae_off_q)
        |-> almost_empty_flag_n_o == ($past(count_q) >= ae_off_q))
        else $error("registered almost-empty wrong");
    async_ae_a: assert property (mode_async && $past(mode_async) && $stable(ae_off_q)
        |-> almost_empty_flag_n_o == (count_q >= ae_off_q))
        else $error("almost-empty threshold wrong");
    async_af_a: assert property (mode_async && $past(mode_async) && $stable(af_off_q)
        |-> almost_full_flag_n_o == (32'(count_q) + 32'(af_off_q) < 32'(DEPTH_C)))
        else $error("almost-full threshold wrong");
    sync_af_a: assert property (!mode_async && $past(!mode_async) && $stable(af_off_q)
        |-> almost_full_flag_n_o
            == (32'($past(count_q)) + 32'(af_off_q) < 32'(DEPTH_C)))
        else $error("registered almost-full wrong");
    retx_hold_a: assert property (retx_go |=> rd_ptr_q == '0 ##0 !wr_ok [*3] ##1
        state_q == DCF_RUN)
        else $error("retransmit recovery length wrong");

    fill_full_c: cover property (!full_flag_n_o);
    empty_again_c: cover property (empty_flag_n_o ##1 !empty_flag_n_o);
    retx_c: cover property (retx_go);
    sync_mode_c: cover property (!mode_async && !almost_empty_flag_n_o);

endmodule // dcf_fifo

/* sim/dcf_peer.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Writer and reader logic on the far side of the buffer
// ----------------------------------------------------------------
module dcf_peer (
    input  wire logic                       clk_i,
    input  wire logic                       push_i,
    input  wire logic                       pop_i,
    output logic                            wr_en_o,
    output logic      [dcf_pkg::DATA_W-1:0] wr_data_o,
    output logic                            rd_en_o
);
    import dcf_pkg::*;
    logic [DATA_W-1:0] seq_q = 18'h00100;

    // Enables follow the requests, data is a running word count
    assign wr_en_o   = push_i;
    assign rd_en_o   = pop_i;
    assign wr_data_o = seq_q;
    // Steps on refused writes too, so a lost word leaves a gap
    always @(posedge clk_i)
        if (wr_en_o)
            seq_q <= seq_q + 18'h00001;
endmodule // dcf_peer

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import dcf_pkg::*;
    localparam int D    = 16;
    localparam int M_AF = 7;
    // ---------------------------------------------------------------
    // Signals, clock and instances
    // ---------------------------------------------------------------
    logic        ref_clk_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h00000000, s_axi_rdata_o;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic        push = 1'b0, pop = 1'b0, out_en_n_i = 1'b1, flag_sync_mode_sel_i = 1'b1;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, wr_en, rd_en, rd_data_oe_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        full_flag_n_o, empty_flag_n_o, almost_empty_flag_n_o, almost_full_flag_n_o;
    logic [DATA_W-1:0] wr_data, rd_data_o, exp_q[$];
    logic [DATA_W-1:0] seq = 18'h00100, last = 18'h00000;
    logic        pp = 1'b0, pq = 1'b0, sm = 1'b0;
    int          cnt = 0, pcnt = 0, ae_n = 7, fails = 0, checked = 0;

    // Free-running clock, also through reset
    always #20 ref_clk_i = ~ref_clk_i;

    dcf_peer u_peer (
        .clk_i(ref_clk_i), .push_i(push), .pop_i(pop),
        .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en)
    );
    dcf_fifo #(.DEPTH(D)) u_dut (
        .ref_clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .rd_data_o, .rd_data_oe_o, .out_en_n_i, .flag_sync_mode_sel_i,
        .full_flag_n_o, .empty_flag_n_o, .almost_empty_flag_n_o, .almost_full_flag_n_o
    );
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            fails++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // A used-up wait bound ends the run at once
    task automatic guard(input int n);
        if (n >= 50)
        begin
            $display("mismatch at %0t: wait ran out, got %h expected %h", $time, n, 0);
            fails++;
            report_and_stop();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge ref_clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o)
                break;
        end
        s_axi_bready_i <= 1'b0;
        guard(n);
        chk(32'(s_axi_bresp_o), 32'(er));
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge ref_clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o)
                break;
        end
        s_axi_rready_i <= 1'b0;
        guard(n);
        chk(s_axi_rdata_o, ed);
        chk(32'(s_axi_rresp_o), 32'(er));
    endtask

    // One clock of traffic; the model settles what the edge just took
    task automatic step(input logic p, input logic q);
        logic rd_ok;
        logic wr_ok;
        @(posedge ref_clk_i);
        rd_ok = pq && (cnt > 0);
        wr_ok = pp && (cnt < D);
        pcnt  = cnt;
        if (rd_ok)
            last = exp_q.pop_front();
        if (wr_ok)
            exp_q.push_back(seq);
        if (pp)
            seq = seq + 18'h00001;
        cnt   = exp_q.size();
        pp    = p;
        pq    = q;
        push <= p;
        pop  <= q;
        #1;
        chk(32'(rd_data_o), 32'(last));
        chk(32'(empty_flag_n_o), 32'(cnt != 0));
        chk(32'(full_flag_n_o), 32'(cnt != D));
        chk(32'(almost_empty_flag_n_o), 32'((sm ? pcnt : cnt) >= ae_n));
        chk(32'(almost_full_flag_n_o), 32'((sm ? pcnt : cnt) < D - M_AF));
    endtask

    task automatic done(input string s);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        $display("test %s done", s);
    endtask

    // Writes stay offered through reset and must leave no trace
    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        push    <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        push    <= 1'b0;
        seq  = seq + 18'h00004;
        exp_q.delete();
        {cnt, pcnt, last, pp, pq, sm, ae_n} = {32'd0, 32'd0, 18'h00000, 3'b000, 32'd7};
        repeat (3) @(posedge ref_clk_i);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_out();
        #1;
        chk(32'(rd_data_oe_o), 32'h0);
        @(posedge ref_clk_i);
        out_en_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1;
        chk(32'(rd_data_oe_o), 32'h1);
        done("outputs");
    endtask

    task automatic t_regs();
        axi_rd(AE_OFS, 32'h00000007, RESP_OKAY);
        axi_rd(AF_OFS, 32'h00000007, RESP_OKAY);
        axi_rd(CTRL_OFS, 32'h00000000, RESP_OKAY);
        axi_rd(STATUS_OFS, 32'h68000000, RESP_OKAY);
        axi_wr(AE_OFS, 32'h00000005, RESP_OKAY);
        axi_rd(AE_OFS, 32'h00000005, RESP_OKAY);
        ae_n = 5;
        axi_wr(8'h10, 32'h00000001, RESP_SLVERR);
        axi_rd(8'h10, 32'h00000000, RESP_SLVERR);
        done("registers");
    endtask

    task automatic t_flow();
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        repeat (D + 1) step(1'b1, 1'b0);
        repeat (D + 1) step(1'b0, 1'b1);
        repeat (3) step(1'b1, 1'b1);
        repeat (3) step(1'b0, 1'b1);
        done("flow");
    endtask

    task automatic t_retx();
        logic [DATA_W-1:0] s0;
        do_reset();
        s0 = seq;
        repeat (3) step(1'b1, 1'b0);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
        axi_wr(CTRL_OFS, 32'h1 << CTRL_RETX_BIT, RESP_OKAY);
        repeat (5) @(posedge ref_clk_i);
        axi_rd(STATUS_OFS, 32'h28000003, RESP_OKAY);
        exp_q = {s0, s0 + 18'h00001, s0 + 18'h00002};
        cnt   = 3;
        pcnt  = 3;
        step(1'b0, 1'b0);
        repeat (4) step(1'b0, 1'b1);
        done("retransmit");
    endtask

    task automatic t_sync();
        @(posedge ref_clk_i);
        flag_sync_mode_sel_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        sm = 1'b1;
        repeat (D) step(1'b1, 1'b0);
        repeat (D) step(1'b0, 1'b1);
        done("sync flags");
    endtask

    // Main sequence
    initial
    begin
        do_reset();
        t_out();
        t_regs();
        t_flow();
        t_retx();
        t_sync();
        report_and_stop();
    end
endmodule // testbench
